// ### camsr_top.sv
module camsr_top #(
   parameter int BIT_CYC = camsr_pkg::BIT_CYC
) (
   // clock and reset
   input  wire logic               mclk,
   input  wire logic               srst,
   // serial link
   input  wire logic               rxd,
   output logic                    txd,
   // camera side
   output camsr_pkg::camsr_cmd_t   cmd,
   output logic [2:0]              latch_q,
   // axi4-lite write
   input  wire logic [7:0]         s_axi_awaddr,
   input  wire logic               s_axi_awvalid,
   output logic                    s_axi_awready,
   input  wire logic [31:0]        s_axi_wdata,
   input  wire logic [3:0]         s_axi_wstrb,
   input  wire logic               s_axi_wvalid,
   output logic                    s_axi_wready,
   output logic [1:0]              s_axi_bresp,
   output logic                    s_axi_bvalid,
   input  wire logic               s_axi_bready,
   // axi4-lite read
   input  wire logic [7:0]         s_axi_araddr,
   input  wire logic               s_axi_arvalid,
   output logic                    s_axi_arready,
   output logic [31:0]             s_axi_rdata,
   output logic [1:0]              s_axi_rresp,
   output logic                    s_axi_rvalid,
   input  wire logic               s_axi_rready
);
   localparam logic [13:0] BIT_LAST = 14'(BIT_CYC - 1);
   localparam logic [13:0] BIT_HALF = 14'(BIT_CYC / 2);

   // registers
   logic [7:0]  station;
   logic [23:0] pt_pos;
   logic [23:0] zf_pos;
   logic [7:0]  preset_chr;
   logic        comm_err;
   logic [1:0]  aux;
   logic [7:0]  aw_addr;
   logic        aw_ok;
   logic        w_ok;
   logic [31:0] w_data;
   logic [3:0]  w_strb;

   // receiver
   logic        rxd_s1;
   logic        rxd_s2;
   logic        rxd_q;
   logic        rx_busy;
   logic [13:0] rx_cnt;
   logic [3:0]  rx_bit;
   logic [7:0]  rx_sh;
   logic        rx_stb;

   // parser
   camsr_pkg::camsr_pstate_t pst;
   logic [7:0]  p_addr;
   logic [7:0]  p_x;
   logic [2:0]  p_len;
   logic [7:0]  d [camsr_pkg::MAX_DATA];

   // transmitter
   logic        tx_act;
   logic [3:0]  tx_idx;
   logic [3:0]  tx_n;
   logic [13:0] tx_cnt;
   logic [9:0]  tx_sh;
   logic [7:0]  rep [camsr_pkg::MAX_DATA];
   logic [2:0]  rep_len;

   // two flops before anything looks at the pin
   always_ff @(posedge mclk) begin
      if (srst) begin
         rxd_s1 <= 1'b1;
         rxd_s2 <= 1'b1;
         rxd_q  <= 1'b1;
      end else begin
         rxd_s1 <= rxd;
         rxd_s2 <= rxd_s1;
         rxd_q  <= rxd_s2;
      end
   end

   // mid-bit sampling, a false start is dropped at the half-bit
   always_ff @(posedge mclk) begin
      if (srst) begin
         rx_busy <= 1'b0;
         rx_cnt  <= 14'h0000;
         rx_bit  <= 4'h0;
         rx_sh   <= 8'h00;
         rx_stb  <= 1'b0;
      end else begin
         rx_stb <= 1'b0;
         if (!rx_busy) begin
            if (rxd_q && !rxd_s2) begin
               rx_busy <= 1'b1;
               rx_cnt  <= BIT_HALF;
               rx_bit  <= 4'h0;
            end
         end else if (rx_cnt != 14'h0000) begin
            rx_cnt <= rx_cnt - 14'h0001;
         end else begin
            rx_cnt <= BIT_LAST;
            rx_bit <= rx_bit + 4'h1;
            if (rx_bit == 4'h0 && rxd_s2) begin
               rx_busy <= 1'b0;
            end else if (rx_bit >= 4'h1 && rx_bit <= 4'h8) begin
               rx_sh <= {rxd_s2, rx_sh[7:1]};
            end else if (rx_bit == 4'h9) begin
               rx_busy <= 1'b0;
               rx_stb  <= rxd_s2;
            end
         end
      end
   end

   // command decode from the stored payload
   camsr_pkg::camsr_cmd_e_t dec;
   wire [7:0] d0 = d[0];
   wire [7:0] d1 = d[1];
   wire       d1_digit = (d1 >= 8'h30) && (d1 <= 8'h39);
   wire       two = (p_len == 3'd2);
   logic      pos_ok;

   always_comb begin
      pos_ok = (p_len == 3'd7);
      for (int i = 1; i < camsr_pkg::MAX_DATA; i++) begin
         if (d[i][7:4] != camsr_pkg::ASC_NIB) begin
            pos_ok = 1'b0;
         end
      end
   end

   always_comb begin
      dec = camsr_pkg::C_NONE;
      if (two) begin
         unique case ({d0, d1})
            {8'h50, 8'h4C}: dec = camsr_pkg::C_PAN_L;
            {8'h50, 8'h52}: dec = camsr_pkg::C_PAN_R;
            {8'h50, 8'h53}: dec = camsr_pkg::C_PAN_S;
            {8'h54, 8'h55}: dec = camsr_pkg::C_TILT_U;
            {8'h54, 8'h44}: dec = camsr_pkg::C_TILT_D;
            {8'h54, 8'h53}: dec = camsr_pkg::C_TILT_S;
            {8'h5A, 8'h49}: dec = camsr_pkg::C_ZOOM_I;
            {8'h5A, 8'h4F}: dec = camsr_pkg::C_ZOOM_O;
            {8'h5A, 8'h53}: dec = camsr_pkg::C_ZOOM_S;
            {8'h46, 8'h4E}: dec = camsr_pkg::C_FOC_N;
            {8'h46, 8'h46}: dec = camsr_pkg::C_FOC_F;
            {8'h46, 8'h53}: dec = camsr_pkg::C_FOC_S;
            {8'h49, 8'h4F}: dec = camsr_pkg::C_IRIS_O;
            {8'h49, 8'h43}: dec = camsr_pkg::C_IRIS_C;
            {8'h49, 8'h53}: dec = camsr_pkg::C_IRIS_S;
            {8'h50, 8'h3F}: dec = camsr_pkg::C_PT_REQ;
            {8'h56, 8'h3F}: dec = camsr_pkg::C_ZF_REQ;
            {8'h4C, 8'h4D}: dec = camsr_pkg::C_TOG_IRIS;
            {8'h4C, 8'h50}: dec = camsr_pkg::C_TOG_PWR;
            {8'h4C, 8'h53}: dec = camsr_pkg::C_TOG_SPD;
            {8'h4C, 8'h3F}: dec = camsr_pkg::C_LATCH_REQ;
            {8'h48, 8'h3F}: dec = camsr_pkg::C_PRE_REQ;
            default: begin
               if (d0 == 8'h48 && d1_digit) begin
                  dec = camsr_pkg::C_PRE_GOTO;
               end else if (d0 == 8'h50 && d1_digit) begin
                  dec = camsr_pkg::C_PRE_STORE;
               end
            end
         endcase
      end else if (pos_ok && d0 == 8'h70) begin
         dec = camsr_pkg::C_PT_GOTO;
      end else if (pos_ok && d0 == 8'h76) begin
         dec = camsr_pkg::C_ZF_GOTO;
      end
   end

   // frame acceptance at the checksum byte
   wire stn_ok  = (station >= camsr_pkg::STN_MIN) && (station <= camsr_pkg::STN_MAX);
   wire is_csum = (rx_sh[7:4] == camsr_pkg::CSUM_NIB);
   wire accept  = rx_stb && (pst == camsr_pkg::P_DATA) && is_csum
                  && (rx_sh[3:0] == p_x[3:0])
                  && (p_addr == station) && stn_ok
                  && (p_len >= 3'd2)
                  && (dec != camsr_pkg::C_NONE) && !tx_act;
   wire [23:0] goto_arg = {d[1][3:0], d[2][3:0], d[3][3:0],
                           d[4][3:0], d[5][3:0], d[6][3:0]};
   wire is_goto = (dec == camsr_pkg::C_PT_GOTO) || (dec == camsr_pkg::C_ZF_GOTO)
                  || (dec == camsr_pkg::C_PRE_GOTO);

   always_ff @(posedge mclk) begin
      if (srst) begin
         pst    <= camsr_pkg::P_IDLE;
         p_addr <= 8'h00;
         p_x    <= 8'h00;
         p_len  <= 3'd0;
         for (int i = 0; i < camsr_pkg::MAX_DATA; i++) begin
            d[i] <= 8'h00;
         end
      end else if (rx_stb) begin
         unique case (pst)
            camsr_pkg::P_IDLE: begin
               if (rx_sh == camsr_pkg::HDR_BYTE) begin
                  pst <= camsr_pkg::P_ADDR;
               end
            end
            camsr_pkg::P_ADDR: begin
               p_addr <= rx_sh;
               p_x    <= rx_sh;
               p_len  <= 3'd0;
               pst    <= camsr_pkg::P_DATA;
            end
            camsr_pkg::P_DATA: begin
               // resync on a fresh header; overlong frames are dropped
               if (is_csum) begin
                  pst <= camsr_pkg::P_IDLE;
               end else if (rx_sh == camsr_pkg::HDR_BYTE) begin
                  pst <= camsr_pkg::P_ADDR;
               end else if (p_len == 3'(camsr_pkg::MAX_DATA)) begin
                  pst <= camsr_pkg::P_IDLE;
               end else begin
                  d[p_len] <= rx_sh;
                  p_x      <= p_x ^ rx_sh;
                  p_len    <= p_len + 3'd1;
               end
            end
            default: pst <= camsr_pkg::P_IDLE;
         endcase
      end
   end

   // command outputs, latches and reply payload
   function automatic logic [7:0] asc(input logic [3:0] n);
      asc = {camsr_pkg::ASC_NIB, n};
   endfunction : asc

   always_ff @(posedge mclk) begin
      if (srst) begin
         cmd     <= '0;
         latch_q <= 3'b000;
         rep_len <= 3'd0;
         for (int i = 0; i < camsr_pkg::MAX_DATA; i++) begin
            rep[i] <= 8'h00;
         end
      end else begin
         cmd.valid <= accept;
         if (accept) begin
            cmd.code <= dec;
            cmd.arg  <= (dec == camsr_pkg::C_PRE_GOTO || dec == camsr_pkg::C_PRE_STORE)
                        ? {20'h00000, d1[3:0]} : goto_arg;
            unique case (dec)
               camsr_pkg::C_TOG_IRIS: latch_q[0] <= !latch_q[0];
               camsr_pkg::C_TOG_PWR:  latch_q[1] <= !latch_q[1];
               camsr_pkg::C_TOG_SPD:  latch_q[2] <= !latch_q[2];
               default: ;
            endcase
            rep_len <= 3'd0;
            unique case (dec)
               camsr_pkg::C_PT_REQ, camsr_pkg::C_ZF_REQ: begin
                  rep_len <= 3'd7;
                  rep[0]  <= (dec == camsr_pkg::C_PT_REQ) ? 8'h50 : 8'h56;
                  for (int i = 0; i < 6; i++) begin
                     rep[i+1] <= asc((dec == camsr_pkg::C_PT_REQ)
                                     ? pt_pos[23-4*i -: 4] : zf_pos[23-4*i -: 4]);
                  end
               end
               camsr_pkg::C_LATCH_REQ: begin
                  rep_len <= 3'd4;
                  rep[0]  <= 8'h4C;
                  rep[1]  <= asc({comm_err, latch_q[2], latch_q[1], latch_q[0]});
                  rep[2]  <= camsr_pkg::CHR_ACTIVE;
                  rep[3]  <= asc({2'b00, aux});
               end
               camsr_pkg::C_PRE_REQ: begin
                  rep_len <= 3'd2;
                  rep[0]  <= 8'h48;
                  rep[1]  <= preset_chr;
               end
               default: ;
            endcase
         end
      end
   end

   // reply checksum over station and payload
   logic [7:0] rep_x;
   always_comb begin
      rep_x = station;
      for (int i = 0; i < camsr_pkg::MAX_DATA; i++) begin
         if (3'(i) < rep_len) begin
            rep_x = rep_x ^ rep[i];
         end
      end
   end

   // byte order: ack, then header, station, payload, checksum
   wire [3:0] tx_last = (rep_len == 3'd0) ? 4'h0 : 4'(rep_len) + 4'h3;
   wire [3:0] nx_idx  = tx_idx + 4'h1;
   logic [7:0] nx_byte;
   always_comb begin
      if (nx_idx == 4'h1) begin
         nx_byte = camsr_pkg::HDR_BYTE;
      end else if (nx_idx == 4'h2) begin
         nx_byte = station;
      end else if (nx_idx == tx_last) begin
         nx_byte = camsr_pkg::CSUM_BASE | {4'h0, rep_x[3:0]};
      end else begin
         nx_byte = rep[3'(nx_idx - 4'h3)];
      end
   end

   // start one cycle after acceptance, so rep is loaded; bytes go back to back
   always_ff @(posedge mclk) begin
      if (srst) begin
         tx_act <= 1'b0;
         tx_idx <= 4'h0;
         tx_n   <= 4'h0;
         tx_cnt <= 14'h0000;
         tx_sh  <= 10'h3FF;
         txd    <= 1'b1;
      end else if (!tx_act) begin
         if (cmd.valid) begin
            tx_act <= 1'b1;
            tx_idx <= 4'h0;
            tx_n   <= 4'h0;
            tx_cnt <= BIT_LAST;
            tx_sh  <= {1'b1, camsr_pkg::ACK_BYTE, 1'b0};
            txd    <= 1'b0;
         end
      end else if (tx_cnt != 14'h0000) begin
         tx_cnt <= tx_cnt - 14'h0001;
      end else begin
         tx_cnt <= BIT_LAST;
         if (tx_n != 4'h9) begin
            tx_n  <= tx_n + 4'h1;
            txd   <= tx_sh[1];
            tx_sh <= {1'b1, tx_sh[9:1]};
         end else if (tx_idx == tx_last) begin
            tx_act <= 1'b0;
         end else begin
            tx_idx <= nx_idx;
            tx_n   <= 4'h0;
            tx_sh  <= {1'b1, nx_byte, 1'b0};
            txd    <= 1'b0;
         end
      end
   end

   // axi4-lite write side
   wire        wr_go  = aw_ok && w_ok && !s_axi_bvalid;
   wire [31:0] wmask  = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};
   wire [31:0] wd     = w_data & wmask;
   wire        wr_stn = wr_go && (aw_addr == camsr_pkg::OFS_STATION);
   wire        wr_pt  = wr_go && (aw_addr == camsr_pkg::OFS_PTPOS);
   wire        wr_zf  = wr_go && (aw_addr == camsr_pkg::OFS_ZFPOS);
   wire        wr_cam = wr_go && (aw_addr == camsr_pkg::OFS_CAMST);
   wire        wr_hit = wr_stn || wr_pt || wr_zf || wr_cam;

   always_ff @(posedge mclk) begin
      if (srst) begin
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= camsr_pkg::RESP_OKAY;
         aw_ok   <= 1'b0;
         w_ok    <= 1'b0;
         aw_addr <= 8'h00;
         w_data  <= 32'h00000000;
         w_strb  <= 4'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            s_axi_awready <= 1'b0;
            aw_ok   <= 1'b1;
            aw_addr <= {s_axi_awaddr[7:2], 2'b00};
         end
         if (s_axi_wvalid && s_axi_wready) begin
            s_axi_wready <= 1'b0;
            w_ok   <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         if (wr_go) begin
            aw_ok        <= 1'b0;
            w_ok         <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_hit ? camsr_pkg::RESP_OKAY : camsr_pkg::RESP_SLVERR;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid  <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
         end
      end
   end

   // station is software-set at installation only; frames never touch it
   always_ff @(posedge mclk) begin
      if (srst) begin
         station    <= camsr_pkg::RST_STATION;
         pt_pos     <= camsr_pkg::RST_POS;
         zf_pos     <= camsr_pkg::RST_POS;
         preset_chr <= camsr_pkg::RST_PRESET;
         comm_err   <= 1'b0;
         aux        <= 2'b00;
      end else begin
         if (wr_stn && w_strb[0]) begin
            station <= w_data[7:0];
         end
         if (wr_pt) begin
            pt_pos <= (pt_pos & ~wmask[23:0]) | wd[23:0];
         end
         if (wr_zf) begin
            zf_pos <= (zf_pos & ~wmask[23:0]) | wd[23:0];
         end
         if (wr_cam && w_strb[0]) begin
            preset_chr <= w_data[7:0];
         end
         if (wr_cam && w_strb[1]) begin
            comm_err <= w_data[camsr_pkg::CAMST_ERR_BIT];
            aux      <= w_data[camsr_pkg::CAMST_AUX_LSB +: 2];
         end
         // a goto accepted in the same cycle wins over software
         if (accept && is_goto) begin
            preset_chr <= camsr_pkg::CHR_ACTIVE;
         end
      end
   end

   // axi4-lite read side
   wire [7:0] ra = {s_axi_araddr[7:2], 2'b00};
   logic [31:0] rd_mux;
   logic        rd_hit;
   always_comb begin
      rd_hit = 1'b1;
      unique case (ra)
         camsr_pkg::OFS_STATION: rd_mux = {24'h000000, station};
         camsr_pkg::OFS_PTPOS:   rd_mux = {8'h00, pt_pos};
         camsr_pkg::OFS_ZFPOS:   rd_mux = {8'h00, zf_pos};
         camsr_pkg::OFS_CAMST:   rd_mux = {21'h000000, aux, comm_err, preset_chr};
         camsr_pkg::OFS_LATCH:   rd_mux = {27'h0000000, tx_act, 1'b0, latch_q};
         camsr_pkg::OFS_LASTCMD: rd_mux = {3'h0, cmd.code, cmd.arg};
         default: begin
            rd_mux = 32'h00000000;
            rd_hit = 1'b0;
         end
      endcase
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h00000000;
         s_axi_rresp   <= camsr_pkg::RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rdata   <= rd_mux;
         s_axi_rresp   <= rd_hit ? camsr_pkg::RESP_OKAY : camsr_pkg::RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid  <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end
endmodule : camsr_top

// ### camsr_pkg.sv
package camsr_pkg;
   localparam int CLK_HZ = 100_000_000;
   localparam int BAUD   = 9600;
   localparam int BIT_CYC = CLK_HZ / BAUD;
   localparam int CNT_W  = 14;
   localparam int MAX_DATA = 7;

   localparam logic [7:0] HDR_BYTE   = 8'hF8;
   localparam logic [7:0] ACK_BYTE   = 8'h06;
   localparam logic [3:0] CSUM_NIB   = 4'h8;
   localparam logic [7:0] CSUM_BASE  = 8'h80;
   localparam logic [3:0] ASC_NIB    = 4'h3;
   localparam logic [7:0] STN_MIN    = 8'h01;
   localparam logic [7:0] STN_MAX    = 8'hDF;
   localparam logic [7:0] CHR_ACTIVE = 8'h41;
   localparam logic [7:0] CHR_QUERY  = 8'h3F;

   // register byte offsets
   localparam logic [7:0] OFS_STATION = 8'h00;
   localparam logic [7:0] OFS_PTPOS   = 8'h04;
   localparam logic [7:0] OFS_ZFPOS   = 8'h08;
   localparam logic [7:0] OFS_CAMST   = 8'h0C;
   localparam logic [7:0] OFS_LATCH   = 8'h10;
   localparam logic [7:0] OFS_LASTCMD = 8'h14;

   // camera status and latch register fields
   localparam int CAMST_ERR_BIT = 8;
   localparam int CAMST_AUX_LSB = 9;
   localparam int LATCH_BUSY_BIT = 4;

   localparam logic [7:0]  RST_STATION = 8'h01;
   localparam logic [7:0]  RST_PRESET  = 8'h30;
   localparam logic [23:0] RST_POS     = 24'h000000;

   localparam logic [1:0] RESP_OKAY   = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   typedef enum logic [4:0] {
      C_NONE = 5'h00, C_PAN_L = 5'h01, C_PAN_R = 5'h02, C_PAN_S = 5'h03,
      C_TILT_U = 5'h04, C_TILT_D = 5'h05, C_TILT_S = 5'h06,
      C_ZOOM_I = 5'h07, C_ZOOM_O = 5'h08, C_ZOOM_S = 5'h09,
      C_FOC_N = 5'h0A, C_FOC_F = 5'h0B, C_FOC_S = 5'h0C,
      C_IRIS_O = 5'h0D, C_IRIS_C = 5'h0E, C_IRIS_S = 5'h0F,
      C_PT_GOTO = 5'h10, C_ZF_GOTO = 5'h11, C_PT_REQ = 5'h12, C_ZF_REQ = 5'h13,
      C_TOG_IRIS = 5'h14, C_TOG_PWR = 5'h15, C_TOG_SPD = 5'h16,
      C_LATCH_REQ = 5'h17, C_PRE_GOTO = 5'h18, C_PRE_STORE = 5'h19,
      C_PRE_REQ = 5'h1A
   } camsr_cmd_e_t;

   typedef enum logic [1:0] {
      P_IDLE = 2'b00,
      P_ADDR = 2'b01,
      P_DATA = 2'b10
   } camsr_pstate_t;

   typedef struct packed {
      logic         valid;
      camsr_cmd_e_t code;
      logic [23:0]  arg;
   } camsr_cmd_t;
endpackage : camsr_pkg

// ### camsr_chk_assertions.sv
module camsr_chk #(
   parameter int BIT_CYC = 16
) (
   // clock and reset
   input wire logic                  mclk,
   input wire logic                  srst,
   // watched outputs and qualifiers
   input wire logic                  txd,
   input wire camsr_pkg::camsr_cmd_t cmd,
   input wire logic [2:0]            latch_q,
   input wire logic                  s_axi_awvalid,
   input wire logic                  s_axi_awready,
   input wire logic                  s_axi_wvalid,
   input wire logic                  s_axi_wready,
   input wire logic                  s_axi_bvalid,
   input wire logic                  s_axi_arvalid,
   input wire logic                  s_axi_arready,
   input wire logic                  s_axi_rvalid
);
   // start bit plus data bit 0 of the ack are low, bit 1 high
   localparam int D1 = 2 * BIT_CYC - 7;
   localparam int D2 = 9 * BIT_CYC + 1;
   default clocking @(posedge mclk); endclocking
   default disable iff (srst);
   sequence s_start; ##1 (!txd) [*8]; endsequence
   property p_ack; cmd.valid |-> s_start ##D1 txd; endproperty
   property p_stop; cmd.valid |-> ##D2 txd; endproperty
   property p_pulse; cmd.valid |=> !cmd.valid; endproperty
   property p_latch; !$stable(latch_q) |-> cmd.valid || $past(cmd.valid); endproperty
   // both halves land in holding flops first, so the answer shows two edges later
   property p_aw; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##2 s_axi_bvalid; endproperty
   property p_bw; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
   property p_ar; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
   property p_arlow; s_axi_rvalid |-> !s_axi_arready; endproperty
   a_ack: assert property (p_ack) else $error("ack start timing");
   a_stop: assert property (p_stop) else $error("ack stop bit");
   a_pulse: assert property (p_pulse) else $error("cmd valid not a pulse");
   a_latch: assert property (p_latch) else $error("latch moved alone");
   a_aw: assert property (p_aw) else $error("write answer late");
   a_bw: assert property (p_bw) else $error("write ready during answer");
   a_ar: assert property (p_ar) else $error("read answer late");
   a_arlow: assert property (p_arlow) else $error("read ready during answer");
endmodule : camsr_chk

// ### camsr_host.sv
module camsr_host #(
   parameter int BIT_CYC = 16
) (
   // clock
   input wire logic mclk,
   // serial link
   output logic     rxd,
   input wire logic txd
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] rxq[$];
   logic [7:0] rb;
   initial rxd = 1'h1;
   function automatic logic [7:0] cs(input logic [7:0] q[$]);
      logic [7:0] x;
      x = 8'h00;
      foreach (q[i]) x ^= q[i];
      return {4'h8, x[3:0]};
   endfunction : cs
   task automatic send_byte(input logic [7:0] b);
      logic [9:0] f;
      f = {1'h1, b, 1'h0};
      for (int i = 0; i < 10; i++) begin
         rxd <= f[i];
         repeat (BIT_CYC) @(posedge mclk);
      end
   endtask : send_byte
   // bad flips the checksum so a silent discard can be provoked
   task automatic send_frame(input logic [7:0] q[$], input logic bad);
      send_byte(8'hF8);
      foreach (q[i]) send_byte(q[i]);
      send_byte(cs(q) ^ {7'h00, bad});
   endtask : send_frame
   // mid-bit sampling, lsb first
   initial forever begin
      @(negedge txd);
      repeat (BIT_CYC / 2) @(posedge mclk);
      for (int i = 0; i < 8; i++) begin
         repeat (BIT_CYC) @(posedge mclk);
         rb[i] = txd;
      end
      repeat (BIT_CYC) @(posedge mclk);
      rxq.push_back(rb);
   end
endmodule : camsr_host

// ### camsr_tb_top.sv
module camsr_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int BIT_CYC = 16;
   logic mclk = 1'h0, srst = 1'h1, rxd, txd;
   camsr_pkg::camsr_cmd_t cmd;
   logic [2:0]  latch_q;
   logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
   logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, s_axi_awready, s_axi_wready;
   logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   int          failures = 0, total_checks = 0;
   string       pairs = "PLPRPSTUTDTSZIZOZSFNFFFSIOICIS";
   always #5 mclk = ~mclk;
   camsr_top #(.BIT_CYC(BIT_CYC)) u_camsr_top (.mclk, .srst, .rxd, .txd, .cmd, .latch_q,
      .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF),
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready);
   camsr_host #(.BIT_CYC(BIT_CYC)) u_camsr_host (.mclk, .rxd, .txd);
   task automatic summarize();
      if (failures == 0 && total_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : summarize
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      total_checks++;
      if (g !== e) begin
         failures++;
         $display("CHECK FAILED %0t got %h exp %h", $time, g, e);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] er = camsr_pkg::RESP_OKAY);
      int n;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      for (n = 0; n < 50; n++) begin
         @(posedge mclk);
         if (s_axi_awready) s_axi_awvalid <= 1'h0;
         if (s_axi_wready) s_axi_wvalid <= 1'h0;
         if (s_axi_bvalid) break;
      end
      if (n == 50) failures++;
      if (n == 50) summarize();
      chk(s_axi_bresp, er);
      s_axi_bready <= 1'h0;
      @(posedge mclk);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] e,
                     input logic [1:0] er = camsr_pkg::RESP_OKAY);
      int n;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      for (n = 0; n < 50; n++) begin
         @(posedge mclk);
         if (s_axi_arready) s_axi_arvalid <= 1'h0;
         if (s_axi_rvalid) break;
      end
      if (n == 50) failures++;
      if (n == 50) summarize();
      chk(s_axi_rdata, e);
      chk(s_axi_rresp, er);
      s_axi_rready <= 1'h0;
      @(posedge mclk);
   endtask : rd
   // waits for the bytes, then a quiet spell so extra bytes are caught
   task automatic rx(input logic [7:0] e[$]);
      int n;
      for (n = 0; n < 4000 && u_camsr_host.rxq.size() < e.size(); n++) @(posedge mclk);
      if (n == 4000) failures++;
      if (n == 4000) summarize();
      repeat (30 * BIT_CYC) @(posedge mclk);
      chk(u_camsr_host.rxq.size(), e.size());
      foreach (e[i]) if (i < u_camsr_host.rxq.size()) chk(u_camsr_host.rxq[i], e[i]);
      u_camsr_host.rxq.delete();
   endtask : rx
   initial begin
      repeat (4) @(posedge mclk);
      srst <= 1'h0;
      @(posedge mclk);
      rd(8'h00, 32'h01);
      rd(8'h10, 32'h0);
      wr(8'h40, 32'h0, camsr_pkg::RESP_SLVERR);
      wr(8'h10, 32'h7, camsr_pkg::RESP_SLVERR);
      wr(8'h00, 32'h05);
      wr(8'h04, 32'hABC123);
      wr(8'h08, 32'h123456);
      for (int i = 0; i < 15; i++) begin
         u_camsr_host.send_frame('{8'h05, pairs[2*i], pairs[2*i+1]}, 1'h0);
         rx('{8'h06});
         chk(cmd.code, i + 1);
      end
      u_camsr_host.send_frame('{8'h05, 8'h50, 8'h4C}, 1'h1);
      rx('{});
      u_camsr_host.send_frame('{8'h06, 8'h50, 8'h4C}, 1'h0);
      rx('{});
      u_camsr_host.send_frame('{8'h05, 8'h50, 8'h3F}, 1'h0);
      rx('{8'h06, 8'hF8, 8'h05, 8'h50, 8'h3A, 8'h3B, 8'h3C, 8'h31, 8'h32, 8'h33, 8'h88});
      u_camsr_host.send_byte(8'h06);
      foreach (pairs[j]) if (j < 3) begin
         u_camsr_host.send_frame('{8'h05, 8'h4C, j == 0 ? 8'h4D : j == 1 ? 8'h50 : 8'h53}, 1'h0);
         rx('{8'h06});
         chk(latch_q, (1 << (j + 1)) - 1);
      end
      u_camsr_host.send_frame('{8'h05, 8'h4C, 8'h3F}, 1'h0);
      rx('{8'h06, 8'hF8, 8'h05, 8'h4C, 8'h37, 8'h41, 8'h30, 8'h8F});
      u_camsr_host.send_frame('{8'h05, 8'h48, 8'h33}, 1'h0);
      rx('{8'h06});
      chk(cmd.code, camsr_pkg::C_PRE_GOTO);
      chk(cmd.arg[3:0], 4'h3);
      u_camsr_host.send_frame('{8'h05, 8'h48, 8'h3F}, 1'h0);
      rx('{8'h06, 8'hF8, 8'h05, 8'h48, 8'h41, 8'h8C});
      u_camsr_host.send_frame('{8'h05, 8'h70, 8'h3A, 8'h3B, 8'h3C, 8'h31, 8'h32, 8'h33}, 1'h0);
      rx('{8'h06});
      chk(cmd.code, camsr_pkg::C_PT_GOTO);
      chk(cmd.arg, 32'hABC123);
      u_camsr_host.send_frame('{8'h05, 8'h56, 8'h3F}, 1'h0);
      rx('{8'h06, 8'hF8, 8'h05, 8'h56, 8'h31, 8'h32, 8'h33, 8'h34, 8'h35, 8'h36, 8'h84});
      u_camsr_host.send_frame('{8'h05, 8'h50, 8'h37}, 1'h0);
      rx('{8'h06});
      chk(cmd.code, camsr_pkg::C_PRE_STORE);
      rd(8'h00, 32'h05);
      summarize();
   end
endmodule : camsr_tb_top
bind camsr_top camsr_chk #(.BIT_CYC(BIT_CYC)) u_camsr_chk (.mclk, .srst, .txd, .cmd,
   .latch_q, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
   .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid);
